// File: hdl/wrf_regfile.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Registers are 32 bits; 8 shared globals plus 24 per window.
// - Window count is 2 to 32, windows numbered 0 to count minus 1.
// - Pop and trap return increment window pointer; push decrements it.
// - Numbers 24-31 ins, 16-23 locals, 8-15 outs, 0-7 globals.
// - Out o equals register o+16 after pointer decrements by one.
// - In i equals register i-16 after pointer increments by one.
// - Windows form a ring; highest window's ins are window zero's outs.
// - Register zero reads as zero; writing it changes nothing.
// - Call writes its own address into out register 15.
// - Trap saves both program counters into two locals of next window.
// - Push checks full, pop checks empty, raising the window trap.
// - New pointer of push, pop or trap return landing on a masked window raises full or empty trap.
// - Window pointer is state bits 4:0; arithmetic wraps modulo count.
// - Program counter holds current instruction; next counter the following.
// - Control and status registers are 32-bit readable and writable.
// - State bits 31:28 hold fixed identity, unchanged by state writes.
// - State bits 27:24 hold constant revision, unchanged by state writes.
// - Bits 23:20 hold condition codes, set by state write or cc ops.
// - Bit 23 set on negative result, bit 22 on zero result.
// - Bit 21 records overflow; logical cc operations clear it.
// - Bit 20 records carry or borrow; logical cc operations clear it.
// - Coprocessor and FPU enable bits: 1 enables, 0 disables.
module wrf_regfile import wrf_pkg::*; #(
	parameter int unsigned WINDOW_COUNT = WRF_NWIN_DEF,
	parameter logic [3:0] DESIGN_ID = WRF_ID_DEF, // Arbitrary value
	parameter logic [3:0] DESIGN_REV = WRF_REV_DEF // Arbitrary value
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [4:0] rs1_sel_i,
	input wire logic [4:0] rs2_sel_i,
	output logic [31:0] rs1_data_o,
	output logic [31:0] rs2_data_o,
	input wire logic wr_en_i,
	input wire logic [4:0] rd_sel_i,
	input wire logic [31:0] wr_data_i,
	input wire logic call_i,
	input wire wrf_wop_e wop_i,
	input wire logic advance_i,
	input wire logic branch_i,
	input wire logic [31:0] branch_target_i,
	input wire logic [31:0] trap_target_i,
	input wire wrf_cc_e cc_kind_i,
	input wire logic [31:0] cc_op_a_i,
	input wire logic [31:0] cc_op_b_i,
	input wire logic psw_wr_i,
	input wire logic [31:0] psw_wr_data_i,
	input wire logic mask_wr_i,
	input wire logic [31:0] mask_wr_data_i,
	output logic [31:0] psw_o,
	output logic [31:0] invalid_window_mask_o,
	output logic [31:0] pc_o,
	output logic [31:0] next_instr_counter_o,
	output logic win_overflow_o,
	output logic win_underflow_o,
	output logic cop_enable_o,
	output logic fpu_enable_o
);
	localparam int unsigned WP_W = WRF_PSW_WP_HI - WRF_PSW_WP_LO + 1;
	// A count outside the legal range is accepted but pinned to the nearest bound
	localparam int unsigned NWIN = (WINDOW_COUNT < WRF_NWIN_MIN) ? WRF_NWIN_MIN :
		((WINDOW_COUNT > WRF_NWIN_MAX) ? WRF_NWIN_MAX : WINDOW_COUNT);
	// Only outs and locals are stored per window
	localparam int unsigned WIN_STORE = WRF_REGS_PER_WIN - WRF_WIN_LOCALS;
	localparam int unsigned NPHYS = WRF_NUM_GLOBALS + WIN_STORE * NWIN;
	localparam int unsigned IDX_W = $clog2(NPHYS);
	// Windows are numbered 0 to NWIN-1 with no gaps
	localparam logic [WP_W-1:0] WP_LAST = WP_W'(NWIN - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// The ring stores outs and locals per window (8 each); ins alias the
	// outs of the window above, so no copy is ever needed on push or pop.
	typedef struct packed {
		logic [NPHYS-1:1][31:0] regs;
		logic [31:0] pc;
		logic [31:0] next_instr_counter;
		logic [WP_W-1:0] wp;
		logic [31:0] mask;
		logic [3:0] icc;
		logic cop_en;
		logic fpu_en;
		logic ovf;
		logic unf;
		logic [31:0] rs1;
		logic [31:0] rs2;
	} wrf_state_s;

	wrf_state_s st_r;
	wrf_state_s st_nxt;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [WP_W-1:0] wp_inc(input logic [WP_W-1:0] w);
		wp_inc = (w == WP_LAST) ? '0 : WP_W'(w + 1'b1);
	endfunction

	function automatic logic [WP_W-1:0] wp_dec(input logic [WP_W-1:0] w);
		wp_dec = (w == '0) ? WP_LAST : WP_W'(w - 1'b1);
	endfunction

	// Map an architectural number in a window to a physical slot
	function automatic logic [IDX_W-1:0] phys(input logic [WP_W-1:0] w, input logic [4:0] r);
		logic [WP_W-1:0] ww;
		logic [IDX_W-1:0] base;
		ww = (r[4:3] == WRF_GRP_IN) ? wp_inc(w) : w;
		base = IDX_W'(WRF_NUM_GLOBALS) + IDX_W'(ww) * IDX_W'(WIN_STORE);
		case (r[4:3])
			WRF_GRP_GLOBAL: phys = IDX_W'(r[2:0]);
			WRF_GRP_LOCAL: phys = base + IDX_W'(WRF_WIN_LOCALS) + IDX_W'(r[2:0]);
			default: phys = base + IDX_W'(r[2:0]); // outs and ins
		endcase
	endfunction

	function automatic logic [31:0] rd_reg(input wrf_state_s s, input logic [IDX_W-1:0] p);
		rd_reg = (p == '0) ? '0 : s.regs[p];
	endfunction

	// ----------------------------------------------------------------
	// Ring helpers
	// ----------------------------------------------------------------
	// A move is refused when the window it would land on is marked invalid
	function automatic logic refused(input logic [31:0] m, input logic [WP_W-1:0] w);
		refused = m[w];
	endfunction

	// Fold a written pointer into the ring; values past the last window wrap round
	function automatic logic [WP_W-1:0] wp_fold(input logic [WP_W-1:0] w);
		if (w <= WP_LAST) begin
			wp_fold = w;
		end else begin
			wp_fold = WP_W'(32'(w) % NWIN);
		end
	endfunction

	// Mask bits of absent windows stay zero whatever is written
	function automatic logic [31:0] mask_fold(input logic [31:0] m);
		mask_fold = '0;
		for (int i = 0; i < NWIN; i++) begin
			mask_fold[i] = m[i];
		end
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [WP_W-1:0] wp_new;
		logic [32:0] sum;
		logic [31:0] res;
		logic vflag;
		logic hit;
		logic [IDX_W-1:0] p;
		st_nxt = st_r;
		wp_new = st_r.wp;
		sum = '0;
		res = '0;
		vflag = 1'b0;
		hit = 1'b0;
		p = '0;
		st_nxt.ovf = 1'b0;
		st_nxt.unf = 1'b0;

		// Register write; call return address takes priority
		if (call_i) begin
			p = phys(st_r.wp, WRF_RET_ADDR_REG);
			st_nxt.regs[p] = st_r.pc;
		end else if (wr_en_i && rd_sel_i != '0) begin
			p = phys(st_r.wp, rd_sel_i);
			st_nxt.regs[p] = wr_data_i;
		end

		// Program counters
		// Trap entry further down overrides an advance in the same cycle
		if (advance_i) begin
			st_nxt.pc = st_r.next_instr_counter;
			st_nxt.next_instr_counter = branch_i ? branch_target_i : 32'(st_r.next_instr_counter + WRF_INSTR_STEP);
		end

		// Window movement
		// A refused move keeps the pointer and pulses its flag for one cycle
		case (wop_i)
			WRF_WOP_PUSH: begin
				wp_new = wp_dec(st_r.wp);
				hit = refused(st_r.mask, wp_new);
				st_nxt.ovf = hit;
				if (!hit) begin
					st_nxt.wp = wp_new;
				end
			end
			WRF_WOP_POP, WRF_WOP_TRAP_RET: begin
				wp_new = wp_inc(st_r.wp);
				hit = refused(st_r.mask, wp_new);
				st_nxt.unf = hit;
				if (!hit) begin
					st_nxt.wp = wp_new;
				end
			end
			WRF_WOP_TRAP: begin
				// Trap entry moves down whatever the mask, unless a state write sets the pointer in the same cycle; overflow handling is the handler's job
				wp_new = wp_dec(st_r.wp);
				st_nxt.wp = wp_new;
				st_nxt.regs[phys(wp_new, WRF_TRAP_PC_REG)] = st_r.pc;
				st_nxt.regs[phys(wp_new, WRF_TRAP_NPC_REG)] = st_r.next_instr_counter;
				st_nxt.pc = trap_target_i;
				st_nxt.next_instr_counter = 32'(trap_target_i + WRF_INSTR_STEP);
			end
			default: begin
			end
		endcase

		// Condition codes
		case (cc_kind_i)
			WRF_CC_ADD: begin
				sum = {1'b0, cc_op_a_i} + {1'b0, cc_op_b_i};
				res = sum[31:0];
				vflag = (cc_op_a_i[31] == cc_op_b_i[31]) && (res[31] != cc_op_a_i[31]);
				st_nxt.icc = {res[31], res == '0, vflag, sum[32]};
			end
			WRF_CC_SUB: begin
				sum = {1'b0, cc_op_a_i} - {1'b0, cc_op_b_i};
				res = sum[31:0];
				vflag = (cc_op_a_i[31] != cc_op_b_i[31]) && (res[31] != cc_op_a_i[31]);
				st_nxt.icc = {res[31], res == '0, vflag, sum[32]}; // borrow
			end
			WRF_CC_LOGIC: begin
				res = cc_op_a_i;
				st_nxt.icc = {res[31], res == '0, 1'b0, 1'b0};
			end
			default: begin
			end
		endcase

		// State word write; identity and revision are not stored at all
		if (psw_wr_i) begin
			st_nxt.icc = psw_wr_data_i[WRF_PSW_N:WRF_PSW_C];
			st_nxt.cop_en = psw_wr_data_i[WRF_PSW_COP_EN];
			st_nxt.fpu_en = psw_wr_data_i[WRF_PSW_FPU_EN];
			st_nxt.wp = wp_fold(psw_wr_data_i[WRF_PSW_WP_HI:WRF_PSW_WP_LO]);
		end
		if (mask_wr_i) begin
			st_nxt.mask = mask_fold(mask_wr_data_i);
		end

		// Registered read ports observe the current window
		st_nxt.rs1 = rd_reg(st_r, phys(st_r.wp, rs1_sel_i));
		st_nxt.rs2 = rd_reg(st_r, phys(st_r.wp, rs2_sel_i));
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			// Each field is named so that its reset value can be read off here
			st_r.regs <= '0;
			st_r.pc <= WRF_PC_RESET;
			st_r.next_instr_counter <= WRF_NPC_RESET;
			st_r.wp <= '0;
			st_r.mask <= '0;
			st_r.icc <= '0;
			st_r.cop_en <= 1'b0;
			st_r.fpu_en <= 1'b0;
			st_r.ovf <= 1'b0;
			st_r.unf <= 1'b0;
			st_r.rs1 <= '0;
			st_r.rs2 <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Identity fields and unused bits are constants; all others are flops
	always_comb begin
		psw_o = '0;
		psw_o[WRF_PSW_ID_HI:WRF_PSW_ID_LO] = DESIGN_ID;
		psw_o[WRF_PSW_REV_HI:WRF_PSW_REV_LO] = DESIGN_REV;
		psw_o[WRF_PSW_N:WRF_PSW_C] = st_r.icc;
		psw_o[WRF_PSW_COP_EN] = st_r.cop_en;
		psw_o[WRF_PSW_FPU_EN] = st_r.fpu_en;
		psw_o[WRF_PSW_WP_HI:WRF_PSW_WP_LO] = st_r.wp;
	end

	assign rs1_data_o = st_r.rs1;
	assign rs2_data_o = st_r.rs2;
	assign invalid_window_mask_o = st_r.mask;
	assign pc_o = st_r.pc;
	assign next_instr_counter_o = st_r.next_instr_counter;
	// Trap flags stand for one cycle only; the pipeline must act on them at once
	assign win_overflow_o = st_r.ovf;
	assign win_underflow_o = st_r.unf;
	assign cop_enable_o = st_r.cop_en;
	assign fpu_enable_o = st_r.fpu_en;
endmodule
`default_nettype wire

// File: shared/wrf_pkg.sv
package wrf_pkg;
	localparam int unsigned WRF_XLEN = 32;
	localparam int unsigned WRF_NUM_GLOBALS = 8;
	localparam int unsigned WRF_REGS_PER_WIN = 24;
	localparam int unsigned WRF_WIN_LOCALS = 8;
	localparam int unsigned WRF_NWIN_DEF = 8;
	localparam int unsigned WRF_NWIN_MIN = 2;
	localparam int unsigned WRF_NWIN_MAX = 32;
	// Register number fields
	localparam logic [4:0] WRF_RET_ADDR_REG = 5'h0F;
	localparam logic [4:0] WRF_TRAP_PC_REG = 5'h11;
	localparam logic [4:0] WRF_TRAP_NPC_REG = 5'h12;
	localparam logic [1:0] WRF_GRP_GLOBAL = 2'h0;
	localparam logic [1:0] WRF_GRP_OUT = 2'h1;
	localparam logic [1:0] WRF_GRP_LOCAL = 2'h2;
	localparam logic [1:0] WRF_GRP_IN = 2'h3;
	// State word fields
	localparam int unsigned WRF_PSW_ID_HI = 31;
	localparam int unsigned WRF_PSW_ID_LO = 28;
	localparam int unsigned WRF_PSW_REV_HI = 27;
	localparam int unsigned WRF_PSW_REV_LO = 24;
	localparam int unsigned WRF_PSW_N = 23;
	localparam int unsigned WRF_PSW_Z = 22;
	localparam int unsigned WRF_PSW_V = 21;
	localparam int unsigned WRF_PSW_C = 20;
	localparam int unsigned WRF_PSW_COP_EN = 13;
	localparam int unsigned WRF_PSW_FPU_EN = 12;
	localparam int unsigned WRF_PSW_WP_HI = 4;
	localparam int unsigned WRF_PSW_WP_LO = 0;
	localparam logic [3:0] WRF_ID_DEF = 4'h1;
	localparam logic [3:0] WRF_REV_DEF = 4'h0;
	localparam logic [31:0] WRF_PC_RESET = 32'h0000_0000;
	localparam logic [31:0] WRF_NPC_RESET = 32'h0000_0004;
	localparam logic [31:0] WRF_INSTR_STEP = 32'h0000_0004;
	// Window operations
	typedef enum logic [2:0] {
		WRF_WOP_NONE = 3'h0,
		WRF_WOP_PUSH = 3'h1,
		WRF_WOP_POP = 3'h2,
		WRF_WOP_TRAP_RET = 3'h3,
		WRF_WOP_TRAP = 3'h4
	} wrf_wop_e;
	// Condition-code update kinds
	typedef enum logic [1:0] {
		WRF_CC_NONE = 2'h0,
		WRF_CC_ADD = 2'h1,
		WRF_CC_SUB = 2'h2,
		WRF_CC_LOGIC = 2'h3
	} wrf_cc_e;
endpackage

// File: tb/wrf_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module wrf_pipe_model (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic run_i,
	input wire logic slow_i,
	output logic advance_o
);
	logic ph_r;
	// Slow mode stalls every other cycle, as a pipeline waiting on fetch would
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ph_r <= 1'b0;
			advance_o <= 1'b0;
		end else begin
			ph_r <= ~ph_r;
			advance_o <= run_i && (!slow_i || ph_r);
		end
	end
endmodule
`default_nettype wire

// File: tb/wrf_regfile_checker.sv
`timescale 1ns/10ps
`default_nettype none
module wrf_regfile_checker import wrf_pkg::*; #(
	parameter int unsigned WINDOW_COUNT = WRF_NWIN_DEF,
	parameter logic [3:0] DESIGN_ID = WRF_ID_DEF,
	parameter logic [3:0] DESIGN_REV = WRF_REV_DEF
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [4:0] rs1_sel_i,
	input wire logic [31:0] rs1_data_o,
	input wire wrf_wop_e wop_i,
	input wire wrf_cc_e cc_kind_i,
	input wire logic psw_wr_i,
	input wire logic [31:0] psw_o,
	input wire logic [31:0] invalid_window_mask_o,
	input wire logic win_overflow_o,
	input wire logic win_underflow_o,
	input wire logic cop_enable_o,
	input wire logic fpu_enable_o
);
	logic [4:0] wp, dn, up;
	logic popx;
	assign wp = psw_o[4:0];
	assign dn = (wp == 5'h00) ? 5'(WINDOW_COUNT - 1) : wp - 5'h01;
	assign up = (32'(wp) + 1 == WINDOW_COUNT) ? 5'h00 : wp + 5'h01;
	assign popx = (wop_i == WRF_WOP_POP || wop_i == WRF_WOP_TRAP_RET) && !psw_wr_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	property p_zero;
		rs1_sel_i == 5'h00 |=> rs1_data_o == 32'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("zero reg read");
	property p_id;
		psw_o[31:24] == {DESIGN_ID, DESIGN_REV};
	endproperty
	a_id: assert property (p_id) else $error("identity field");
	property p_push;
		wop_i == WRF_WOP_PUSH && !psw_wr_i && !invalid_window_mask_o[dn] |=> wp == $past(dn);
	endproperty
	a_push: assert property (p_push) else $error("push pointer");
	property p_pop;
		popx && !invalid_window_mask_o[up] |=> wp == $past(up);
	endproperty
	a_pop: assert property (p_pop) else $error("pop pointer");
	property p_ovf;
		wop_i == WRF_WOP_PUSH && !psw_wr_i && invalid_window_mask_o[dn]
			|=> win_overflow_o && $stable(wp);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow");
	property p_unf;
		popx && invalid_window_mask_o[up] |=> win_underflow_o && $stable(wp);
	endproperty
	a_unf: assert property (p_unf) else $error("underflow");
	property p_cc;
		cc_kind_i == WRF_CC_LOGIC && !psw_wr_i |=> psw_o[21:20] == 2'h0;
	endproperty
	a_cc: assert property (p_cc) else $error("logic cc");
	property p_en;
		cop_enable_o == psw_o[WRF_PSW_COP_EN] && fpu_enable_o == psw_o[WRF_PSW_FPU_EN];
	endproperty
	a_en: assert property (p_en) else $error("enables");
	property p_ovf_one;
		wop_i != WRF_WOP_PUSH |=> !win_overflow_o;
	endproperty
	a_ovf_one: assert property (p_ovf_one) else $error("overflow pulse");
	property p_unf_one;
		!(wop_i inside {WRF_WOP_POP, WRF_WOP_TRAP_RET}) |=> !win_underflow_o;
	endproperty
	a_unf_one: assert property (p_unf_one) else $error("underflow pulse");
	property p_trap;
		wop_i == WRF_WOP_TRAP && !psw_wr_i |=> wp == $past(dn);
	endproperty
	a_trap: assert property (p_trap) else $error("trap pointer");
endmodule
bind wrf_regfile wrf_regfile_checker #(.WINDOW_COUNT(WINDOW_COUNT), .DESIGN_ID(DESIGN_ID),
	.DESIGN_REV(DESIGN_REV)) i_chk (.sys_clk_i, .reset_i, .rs1_sel_i, .rs1_data_o, .wop_i,
	.cc_kind_i, .psw_wr_i, .psw_o, .invalid_window_mask_o, .win_overflow_o, .win_underflow_o,
	.cop_enable_o, .fpu_enable_o);
`default_nettype wire

// File: tb/tb_wrf_regfile.sv
`timescale 1ns/10ps
`default_nettype none
module tb_wrf_regfile import wrf_pkg::*;;
	// Odd count so pointer wrap is a true modulo, not a power of two
	localparam int unsigned NW = 5;
	logic sys_clk_i, reset_i, wr_en_i, call_i, advance_i, branch_i, psw_wr_i, mask_wr_i, run, slow;
	logic [4:0] rs1_sel_i, rs2_sel_i, rd_sel_i;
	logic [31:0] wr_data_i, branch_target_i, trap_target_i, cc_op_a_i, cc_op_b_i;
	logic [31:0] psw_wr_data_i, mask_wr_data_i, rs1_data_o, rs2_data_o, psw_o, pc_o;
	logic [31:0] invalid_window_mask_o, next_instr_counter_o;
	logic win_overflow_o, win_underflow_o, cop_enable_o, fpu_enable_o;
	wrf_wop_e wop_i;
	wrf_cc_e cc_kind_i;
	int fail_count, checks, adv_n;
	wrf_regfile #(.WINDOW_COUNT(NW)) i_dut (.sys_clk_i, .reset_i, .rs1_sel_i, .rs2_sel_i,
		.rs1_data_o, .rs2_data_o, .wr_en_i, .rd_sel_i, .wr_data_i, .call_i, .wop_i, .advance_i,
		.branch_i, .branch_target_i, .trap_target_i, .cc_kind_i, .cc_op_a_i, .cc_op_b_i,
		.psw_wr_i, .psw_wr_data_i, .mask_wr_i, .mask_wr_data_i, .psw_o, .invalid_window_mask_o,
		.pc_o, .next_instr_counter_o, .win_overflow_o, .win_underflow_o, .cop_enable_o,
		.fpu_enable_o);
	wrf_pipe_model i_pipe (.sys_clk_i, .reset_i, .run_i(run), .slow_i(slow),
		.advance_o(advance_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		if (advance_i === 1'b1) adv_n++;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [4:0] r, input logic [31:0] d);
		@(posedge sys_clk_i);
		wr_en_i <= 1'b1;
		rd_sel_i <= r;
		wr_data_i <= d;
		@(posedge sys_clk_i);
		wr_en_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] s, input logic [31:0] e, input string nm);
		@(posedge sys_clk_i);
		rs1_sel_i <= s;
		rs2_sel_i <= s;
		@(posedge sys_clk_i);
		#1;
		chk(nm, rs1_data_o, e);
		chk(nm, rs2_data_o, e);
	endtask
	task automatic wop(input wrf_wop_e w, input logic [4:0] e);
		@(posedge sys_clk_i);
		wop_i <= w;
		@(posedge sys_clk_i);
		wop_i <= WRF_WOP_NONE;
		#1;
		chk("wp", 32'(psw_o[4:0]), 32'(e));
	endtask
	task automatic cc(input wrf_cc_e k, input logic [31:0] a, b, input logic [3:0] e);
		@(posedge sys_clk_i);
		cc_kind_i <= k;
		cc_op_a_i <= a;
		cc_op_b_i <= b;
		@(posedge sys_clk_i);
		cc_kind_i <= WRF_CC_NONE;
		#1;
		chk("icc", 32'(psw_o[23:20]), 32'(e));
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_pc_call();
		@(posedge sys_clk_i);
		run <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		slow <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		run <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk("pc", pc_o, 32'(adv_n * 4));
		chk("npc", next_instr_counter_o, 32'(adv_n * 4 + 4));
		@(posedge sys_clk_i);
		call_i <= 1'b1;
		@(posedge sys_clk_i);
		call_i <= 1'b0;
		rd(5'h0F, 32'(adv_n * 4), "ret");
	endtask
	task automatic t_windows();
		wr(5'h01, 32'h0000_1111);
		wr(5'h08, 32'h0000_2222);
		wr(5'h00, 32'hFFFF_FFFF);
		rd(5'h00, 32'h0, "r0");
		wop(WRF_WOP_PUSH, 5'(NW - 1));
		rd(5'h18, 32'h0000_2222, "in0");
		rd(5'h01, 32'h0000_1111, "g1");
		wr(5'h18, 32'h0000_3333);
		wr(5'h10, 32'h0000_4444);
		wop(WRF_WOP_POP, 5'h00);
		rd(5'h08, 32'h0000_3333, "out0");
		rd(5'h10, 32'h0, "loc0");
	endtask
	task automatic t_trap();
		wop(WRF_WOP_TRAP, 5'(NW - 1));
		chk("tpc", pc_o, trap_target_i);
		rd(5'h11, 32'(adv_n * 4), "spc");
		rd(5'h12, 32'(adv_n * 4 + 4), "snpc");
		wop(WRF_WOP_TRAP_RET, 5'h00);
	endtask
	task automatic t_mask_psw();
		@(posedge sys_clk_i);
		mask_wr_i <= 1'b1;
		mask_wr_data_i <= 32'hFFFF_FFFE;
		psw_wr_data_i <= 32'hFFF0_3FFF;
		@(posedge sys_clk_i);
		mask_wr_i <= 1'b0;
		#1;
		chk("mask", invalid_window_mask_o, 32'h0000_001E);
		wop(WRF_WOP_PUSH, 5'h00);
		chk("ovf", 32'(win_overflow_o), 32'h1);
		wop(WRF_WOP_TRAP_RET, 5'h00);
		chk("unf", 32'(win_underflow_o), 32'h1);
		@(posedge sys_clk_i);
		psw_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		psw_wr_i <= 1'b0;
		#1;
		chk("psw", psw_o, {WRF_ID_DEF, WRF_REV_DEF, 4'hF, 8'h3, 7'h0, 5'(31 % NW)});
		chk("en", {30'h0, cop_enable_o, fpu_enable_o}, 32'h3);
	endtask
	task automatic t_order_branch();
		@(posedge sys_clk_i);
		psw_wr_i <= 1'b1;
		psw_wr_data_i <= 32'h0000_0003;
		wop_i <= WRF_WOP_PUSH;
		cc_kind_i <= WRF_CC_ADD;
		cc_op_a_i <= 32'hFFFF_FFFF;
		cc_op_b_i <= 32'h0000_0001;
		@(posedge sys_clk_i);
		psw_wr_i <= 1'b0;
		wop_i <= WRF_WOP_NONE;
		cc_kind_i <= WRF_CC_NONE;
		#1;
		chk("pswpri", psw_o, {WRF_ID_DEF, WRF_REV_DEF, 24'h00_0003});
		chk("en0", {30'h0, cop_enable_o, fpu_enable_o}, 32'h0);
		@(posedge sys_clk_i);
		branch_i <= 1'b1;
		branch_target_i <= 32'h0000_0200;
		slow <= 1'b0;
		run <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		run <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk("bpc", pc_o, 32'h0000_0200);
		chk("bnpc", next_instr_counter_o, 32'h0000_0200);
		@(posedge sys_clk_i);
		branch_i <= 1'b0;
		call_i <= 1'b1;
		wr_en_i <= 1'b1;
		rd_sel_i <= 5'h0F;
		wr_data_i <= 32'h0000_5555;
		@(posedge sys_clk_i);
		call_i <= 1'b0;
		wr_en_i <= 1'b0;
		rd(5'h0F, 32'h0000_0200, "callpri");
	endtask
	initial begin
		{wr_en_i, call_i, branch_i, psw_wr_i, mask_wr_i, run, slow} = '0;
		{rs1_sel_i, rs2_sel_i, rd_sel_i} = '0;
		{wr_data_i, branch_target_i, cc_op_a_i, cc_op_b_i, psw_wr_data_i, mask_wr_data_i} = '0;
		trap_target_i = 32'h0000_0100;
		wop_i = WRF_WOP_NONE;
		cc_kind_i = WRF_CC_NONE;
		reset_i = 1'b1;
		repeat (16) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		#1;
		chk("rst", psw_o, {WRF_ID_DEF, WRF_REV_DEF, 24'h0});
		chk("rnpc", next_instr_counter_o, WRF_NPC_RESET);
		t_pc_call();
		t_windows();
		t_trap();
		cc(WRF_CC_ADD, 32'h7FFF_FFFF, 32'h1, 4'hA);
		cc(WRF_CC_ADD, 32'hFFFF_FFFF, 32'h1, 4'h5);
		cc(WRF_CC_SUB, 32'h0, 32'h1, 4'h9);
		cc(WRF_CC_SUB, 32'h8000_0000, 32'h1, 4'h2);
		cc(WRF_CC_LOGIC, 32'h0, 32'hFFFF_FFFF, 4'h4);
		t_mask_psw();
		t_order_branch();
		wrap_up();
	end
	initial begin
		#100us;
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
